// ---- shared/uef_pkg.sv ----
// package: register map, bit positions and timing constants of the usb event flag block
package uef_pkg;
  // register byte offsets (chosen)
  localparam logic [3:0] OFF_EVENT_FLAGS   = 4'h0;
  localparam logic [3:0] OFF_ERROR_ENABLES = 4'h4;
  localparam logic [3:0] OFF_EVENT_ENABLE  = 4'h8;
  localparam logic [3:0] OFF_CONTROL       = 4'hc;
  localparam logic [3:0] OFF_ERROR_FLAGS   = 4'h0;
  // event flag positions
  localparam int FLAG_W       = 8;
  localparam int BIT_STALL    = 7;
  localparam int BIT_ATTACH   = 6;
  localparam int BIT_RESUME   = 5;
  localparam int BIT_IDLE     = 4;
  localparam int BIT_TOKEN    = 3;
  localparam int BIT_FRAME    = 2;
  localparam int BIT_ERRSUM   = 1;
  localparam int BIT_RESET_DT = 0;
  // error enable positions
  localparam int BIT_BITSTUFF = 7;
  localparam int BIT_MATRIX   = 6;
  localparam int BIT_DMA      = 5;
  localparam int BIT_TURN     = 4;
  localparam int BIT_FSIZE    = 3;
  localparam int BIT_CRC16    = 2;
  localparam int BIT_CRC5_EOF = 1;
  localparam int BIT_PID      = 0;
  // control register bit
  localparam int BIT_HOST_EN  = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // timing
  localparam int CLK_HZ       = 25000000;
  localparam int K_STATE_NS   = 2500;
  localparam int IDLE_US      = 3000;
  localparam int K_STATE_CYC  = (K_STATE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int IDLE_CYC     = IDLE_US * (CLK_HZ / 1000000);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- verilog/uef_flag_bit.sv ----
// one sticky flag: hardware set wins over write-one clear
`timescale 1ns/1ps
`default_nettype none
module uef_flag_bit (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // set and clear
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  // state
  output var  logic flag_ff
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_ff <= 1'b0;
    else if (set_pulse)
      flag_ff <= 1'b1;
    else if (clr_pulse)
      flag_ff <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- verilog/uef_hold_timer.sv ----
// counts how long a condition has held and pulses once when the limit is reached
`timescale 1ns/1ps
`default_nettype none
module uef_hold_timer #(
  parameter int LIMIT = 63
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // condition and result
  input  wire logic cond,
  output var  logic reached_ff,
  output var  logic hit_pulse
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] count_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_ff <= '0;
    else if (!cond)
      count_ff <= '0;
    else if (count_ff != LIM)
      count_ff <= count_ff + CW'(1);
  end

  assign hit_pulse = cond && (count_ff == LIM - CW'(1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reached_ff <= 1'b0;
    else
      reached_ff <= cond && (count_ff >= LIM - CW'(1));
  end
endmodule
`default_nettype wire

// ---- verilog/uef_event_flags.sv ----
// usb event flag, error enable and interrupt request logic with an axi4-lite slave
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uef_event_flags #(
  parameter int IDLE_CYCLES = uef_pkg::IDLE_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // axi4-lite read data
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  // bus and protocol events, one-cycle pulses except the bus_idle, line_se0 and k_state levels
  input  wire logic        stall_seen,
  input  wire logic        attach_seen,
  input  wire logic        bus_idle,
  input  wire logic        line_se0,
  input  wire logic        k_state,
  input  wire logic        token_complete,
  input  wire logic        sof_received,
  input  wire logic        sof_threshold,
  input  wire logic        usb_reset_seen,
  input  wire logic        detach_seen,
  input  wire logic [7:0]  error_events,
  // transfer status queue
  output var  logic        status_queue_advance,
  // processor interrupt
  output var  logic        controller_cpu_irq_flag
);
  localparam logic [7:0] W_MASK = 8'hfd;

  logic [7:0] usb_error_enables_ff;
  logic [7:0] usb_event_enable_reg_ff;
  logic [7:0] error_flags_ff;
  logic       host_role_enable_ff;
  logic [7:0] flags;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic       quiet_reached;
  logic       resume_hit;
  logic       idle_hit;
  logic       aw_held_ff;
  logic       w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic       wr_fire;
  logic       err_any;

  // quiet-bus qualifier for attach timing; resume and idle timing each have their own count
  uef_hold_timer #(.LIMIT(uef_pkg::K_STATE_CYC)) u_quiet (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cond       (bus_idle && !line_se0),
    .reached_ff (quiet_reached),
    .hit_pulse  ()
  );
  uef_hold_timer #(.LIMIT(uef_pkg::K_STATE_CYC)) u_resume (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cond       (k_state),
    .reached_ff (),
    .hit_pulse  (resume_hit)
  );
  uef_hold_timer #(.LIMIT(IDLE_CYCLES)) u_idle (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cond       (bus_idle),
    .reached_ff (),
    .hit_pulse  (idle_hit)
  );

  // errors masked by the per-error enables; bit 1 role meaning is in the source
  assign err_any = |(error_events & usb_error_enables_ff);

  always_comb
  begin
    set_vec                          = '0;
    set_vec[uef_pkg::BIT_STALL]      = stall_seen;
    set_vec[uef_pkg::BIT_ATTACH]     = attach_seen && host_role_enable_ff
                                       && quiet_reached && !line_se0;
    set_vec[uef_pkg::BIT_RESUME]     = resume_hit;
    set_vec[uef_pkg::BIT_IDLE]       = idle_hit;
    set_vec[uef_pkg::BIT_TOKEN]      = token_complete;
    set_vec[uef_pkg::BIT_FRAME]      = host_role_enable_ff ? sof_threshold
                                                           : sof_received;
    set_vec[uef_pkg::BIT_RESET_DT]   = host_role_enable_ff ? detach_seen
                                                           : usb_reset_seen;
  end

  // write-one clear on the low byte only; bit 1 cannot be cleared here, only by clearing the error flags at OFF_CONTROL
  always_comb
  begin
    clr_vec = '0;
    if (wr_fire && awaddr_ff == uef_pkg::OFF_EVENT_FLAGS && wstrb_ff[0])
      clr_vec = wdata_ff[7:0] & W_MASK;
  end

  genvar gi;
  generate
    for (gi = 0; gi < uef_pkg::FLAG_W; gi++)
    begin : g_flag
      if (gi == uef_pkg::BIT_ERRSUM)
      begin : g_sum
        // summary follows the live latched error state
        assign flags[gi] = |error_flags_ff;
      end
      else
      begin : g_sticky
        uef_flag_bit u_bit (
          .aclk      (aclk),
          .aresetn   (aresetn),
          .set_pulse (set_vec[gi]),
          .clr_pulse (clr_vec[gi]),
          .flag_ff   (flags[gi])
        );
      end
    end
  endgenerate

  // detailed error flags latch only enabled errors, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      error_flags_ff <= uef_pkg::FLAGS_RESET;
    else if (wr_fire && awaddr_ff == uef_pkg::OFF_CONTROL && wstrb_ff[0])
      error_flags_ff <= (error_flags_ff & ~wdata_ff[7:0])
                        | (error_events & usb_error_enables_ff);
    else
      error_flags_ff <= error_flags_ff | (error_events & usb_error_enables_ff);
  end

  // token done clear moves the status queue on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_queue_advance <= 1'b0;
    else
      status_queue_advance <= clr_vec[uef_pkg::BIT_TOKEN]
                              && flags[uef_pkg::BIT_TOKEN];
  end

  // resume enable is left to software outside suspend, not enforced here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      controller_cpu_irq_flag <= 1'b0;
    else
      controller_cpu_irq_flag <= |(flags & usb_event_enable_reg_ff);
  end

  // axi write: address and data accepted in either order
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= uef_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= awaddr_ff[1:0] == 2'b00 ? uef_pkg::RESP_OKAY : uef_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      usb_error_enables_ff    <= uef_pkg::FLAGS_RESET;
      usb_event_enable_reg_ff <= uef_pkg::FLAGS_RESET;
      host_role_enable_ff     <= 1'b0;
    end
    else if (wr_fire && wstrb_ff[0])
    begin
      case (awaddr_ff)
        uef_pkg::OFF_ERROR_ENABLES: usb_error_enables_ff <= wdata_ff[7:0];
        uef_pkg::OFF_EVENT_ENABLE:  usb_event_enable_reg_ff <= wdata_ff[7:0];
        uef_pkg::OFF_CONTROL:       host_role_enable_ff <= wdata_ff[uef_pkg::BIT_HOST_EN];
        default:                    ;
      endcase
    end
  end

  // axi read: one cycle after arvalid is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= uef_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= uef_pkg::RESP_OKAY;
      case (s_axi_araddr)
        uef_pkg::OFF_EVENT_FLAGS:   s_axi_rdata <= {24'h000000, flags};
        uef_pkg::OFF_ERROR_ENABLES: s_axi_rdata <= {24'h000000, usb_error_enables_ff};
        uef_pkg::OFF_EVENT_ENABLE:  s_axi_rdata <= {24'h000000, usb_event_enable_reg_ff};
        uef_pkg::OFF_CONTROL:       s_axi_rdata <= {23'h000000, error_flags_ff,
                                                    host_role_enable_ff};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= uef_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb/uef_event_flags_monitor.sv ----
// assertions on the register bus and queue advance of the usb event flag block
`timescale 1ns/1ps
`default_nettype none
module uef_event_flags_monitor (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // transfer status queue
  input wire logic        status_queue_advance
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
    else $error("upper read bits set");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_write_answer: assert property (wr_taken |=> ##[0:1] s_axi_bvalid)
    else $error("write answer late");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_adv_pulse: assert property (status_queue_advance |=> !status_queue_advance)
    else $error("queue advance longer than one cycle");
endmodule
bind uef_event_flags uef_event_flags_monitor u_mon (.*);
`default_nettype wire

// ---- tb/uef_usb_side.sv ----
// behavioural usb bus side: line levels and event pulses
`timescale 1ns/1ps
`default_nettype none
module uef_usb_side (
  // clock
  input wire logic       aclk,
  // events and line levels
  output var logic [6:0] ev_pulse,
  output var logic [7:0] err_pulse,
  output var logic       idle_lvl,
  output var logic       se0_lvl,
  output var logic       k_lvl
);
  initial
  begin
    ev_pulse = 7'h0;
    err_pulse = 8'h0;
    idle_lvl = 1'b0;
    se0_lvl = 1'b1;
    k_lvl = 1'b0;
  end
  // a slow answer lets the bus sit a few cycles before the event
  task automatic fire(input int idx, input logic [7:0] err, input bit slow);
    repeat (slow ? 3 : 0) @(posedge aclk);
    @(posedge aclk);
    if (idx >= 0)
      ev_pulse[idx] <= 1'b1;
    err_pulse <= err;
    @(posedge aclk);
    ev_pulse <= 7'h0;
    err_pulse <= 8'h0;
  endtask
  task automatic lines(input logic idle, input logic se0, input logic k, input int n);
    @(posedge aclk);
    idle_lvl <= idle;
    se0_lvl <= se0;
    k_lvl <= k;
    repeat (n) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/uef_event_flags_tb.sv ----
// self-checking bench for the usb event flag block
`timescale 1ns/1ps
`default_nettype none
module uef_event_flags_tb;
  localparam logic [3:0] FL = uef_pkg::OFF_EVENT_FLAGS;
  localparam logic [3:0] EE = uef_pkg::OFF_ERROR_ENABLES;
  localparam logic [3:0] EN = uef_pkg::OFF_EVENT_ENABLE;
  localparam logic [3:0] CT = uef_pkg::OFF_CONTROL;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        stall_seen, attach_seen, token_complete, sof_received, sof_threshold;
  logic        usb_reset_seen, detach_seen, bus_idle, line_se0, k_state;
  logic        status_queue_advance, controller_cpu_irq_flag;
  logic [6:0]  ev;
  logic [7:0]  error_events;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_adv = 0;
  // byte strobes offered by the next write; full word unless a scenario says otherwise
  logic [3:0]  wr_strb = 4'hf;
  assign {detach_seen, usb_reset_seen, sof_threshold, sof_received, token_complete,
          attach_seen, stall_seen} = ev;
  uef_event_flags #(.IDLE_CYCLES(20)) u_dut (.*);
  uef_usb_side u_usb (.aclk(aclk), .ev_pulse(ev), .err_pulse(error_events),
    .idle_lvl(bus_idle), .se0_lvl(line_se0), .k_lvl(k_state));
  always #20 aclk = ~aclk;
  always @(posedge aclk)
    if (status_queue_advance === 1'b1)
      n_adv++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= wr_strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_d, exp);
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({31'h0, controller_cpu_irq_flag}, {31'h0, exp});
  endtask
  task automatic t_regs;
    rchk(FL, 32'h0);
    rchk(EE, 32'h0);
    wr(EE, 32'hffff_ffff);
    check(r, uef_pkg::RESP_OKAY);
    rchk(EE, 32'hff);
    check(r, uef_pkg::RESP_OKAY);
    wr(EE, 32'h0);
    // a write without the low byte lane must leave the enables alone
    wr_strb = 4'he;
    wr(EE, 32'hff);
    wr_strb = 4'hf;
    rchk(EE, 32'h0);
    wr(4'h1, 32'h1);
    check(r, uef_pkg::RESP_SLVERR);
    rchk(4'h2, 32'h0);
    check(r, uef_pkg::RESP_SLVERR);
  endtask
  task automatic t_flags;
    int src[6] = '{0, 2, 3, 5, 4, 6};
    int pos[6] = '{7, 3, 2, 0, 2, 0};
    foreach (src[i])
    begin
      wr(CT, {31'h0, i > 3});
      u_usb.fire(src[i], 8'h00, i[0]);
      rchk(FL, 32'h1 << pos[i]);
      wr(FL, 32'h0);
      rchk(FL, 32'h1 << pos[i]);
      wr(FL, 32'h1 << pos[i]);
      rchk(FL, 32'h0);
    end
    wr(CT, 32'h0);
    check(n_adv, 1);
  endtask
  task automatic t_errors;
    for (int b = 0; b < 8; b++)
    begin
      u_usb.fire(-1, 8'h1 << b, 1'b0);
      rchk(FL, 32'h0);
      wr(EE, 32'h1 << b);
      u_usb.fire(-1, 8'h1 << b, 1'b1);
      rchk(FL, 32'h2);
      wr(FL, 32'h2);
      rchk(FL, 32'h2);
      rchk(CT, 32'h2 << b);
      wr(CT, 32'hff);
      rchk(CT, 32'h1);
      wr(CT, 32'h0);
      rchk(FL, 32'h0);
      wr(EE, 32'h0);
    end
  endtask
  task automatic t_irq;
    wr(EE, 32'h4);
    u_usb.fire(-1, 8'h04, 1'b0);
    // resume stays disabled outside suspend
    wr(EN, 32'h80);
    irq_is(1'b0);
    wr(EN, 32'h82);
    irq_is(1'b1);
    repeat (20) @(posedge aclk);
    irq_is(1'b1);
    wr(CT, 32'h4);
    wr(CT, 32'h0);
    irq_is(1'b0);
    u_usb.fire(0, 8'h00, 1'b1);
    irq_is(1'b1);
    wr(FL, 32'h80);
    irq_is(1'b0);
    wr(EN, 32'h0);
    wr(EE, 32'h0);
  endtask
  task automatic t_timers;
    // k-state seen for 62 edges is just short of the limit
    u_usb.lines(1'b0, 1'b0, 1'b1, 61);
    u_usb.lines(1'b0, 1'b0, 1'b0, 2);
    rchk(FL, 32'h0);
    u_usb.lines(1'b0, 1'b0, 1'b1, 68);
    rchk(FL, 32'h20);
    wr(FL, 32'h20);
    u_usb.lines(1'b1, 1'b0, 1'b0, 18);
    rchk(FL, 32'h0);
    u_usb.lines(1'b1, 1'b0, 1'b0, 20);
    rchk(FL, 32'h10);
    wr(FL, 32'h10);
    u_usb.lines(1'b1, 1'b0, 1'b0, 40);
    u_usb.fire(1, 8'h00, 1'b0);
    rchk(FL, 32'h0);
    wr(CT, 32'h1);
    u_usb.fire(1, 8'h00, 1'b1);
    rchk(FL, 32'h40);
    wr(FL, 32'h40);
    u_usb.lines(1'b1, 1'b1, 1'b0, 70);
    u_usb.fire(1, 8'h00, 1'b0);
    rchk(FL, 32'h0);
    // bus active a moment ago: the quiet time has not yet elapsed
    u_usb.lines(1'b0, 1'b0, 1'b0, 2);
    u_usb.lines(1'b1, 1'b0, 1'b0, 10);
    u_usb.fire(1, 8'h00, 1'b0);
    rchk(FL, 32'h0);
    wr(CT, 32'h0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_flags;
    t_errors;
    t_irq;
    t_timers;
    finish_test;
  end
  // about 1000 cycles are expected; a hang is cut well beyond that
  initial
  begin
    #200us;
    n_mismatch++;
    finish_test;
  end
endmodule
`default_nettype wire
